// File: sac_config_accum.sv
// apb slave with converter configuration, sequencing and result accumulator
`default_nettype none

module sac_config_accum (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [sac_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sac_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [sac_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic soc_pulse,
    input wire logic core_done,
    input wire logic [9:0] core_result,
    output logic conv_start,
    output logic conv_track,
    output logic sar_clk,
    output logic eight_bit_mode_select,
    output logic amplifier_gain_select,
    output logic busy
);
    import sac_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    logic [REG_W-1:0] conv_cfg;
    logic [2:0] shift_justify_select;
    logic [2:0] repeat_count;
    logic accumulate_enable;
    logic enable;
    logic burst_mode_enable;
    logic conversion_done_flag;
    logic done_mask;
    logic [15:0] acc;
    logic [15:0] fmt;
    logic [15:0] sample;
    logic [6:0] burst_left;
    logic [1:0] track_cnt;
    logic sar_tick;
    logic track_mode_select;
    sac_state_type state;
    logic setup;
    logic wr;
    logic [7:0] idx;
    logic mapped;
    logic [REG_W-1:0] rd_byte;
    logic sw_start;
    logic start_req;
    logic more;
    logic launch;
    logic to_track;
    logic done_set;

    assign idx = paddr[ADDR_W-1:2];
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite && pready && pstrb[0];
    assign pready = 1'b1;
    assign eight_bit_mode_select = conv_cfg[CFG_EIGHT_BIT];
    assign track_mode_select = conv_cfg[CFG_TRACK];
    assign amplifier_gain_select = conv_cfg[CFG_GAIN];
    assign busy = (state != st_idle);
    assign conv_track = (state == st_track);
    assign irq = conversion_done_flag && done_mask;

    // ************************************************************
    // sar clock
    // ************************************************************
    sac_sar_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .divider(conv_cfg[CFG_DIV_LSB +: CFG_DIV_W]),
        .sar_clk(sar_clk),
        .sar_tick(sar_tick)
    );

    // width of the sample follows the resolution the core was set to
    assign sample = eight_bit_mode_select ? {8'h00, core_result[7:0]} : {6'h00, core_result};

    // read formatting, reserved codes read unshifted
    always_comb begin
        if (shift_justify_select == SJ_LEFT) begin
            fmt = acc << LEFT_SHIFT;
        end else if (shift_justify_select < SJ_LEFT) begin
            fmt = acc >> shift_justify_select;
        end else begin
            fmt = acc;
        end
    end

    // ************************************************************
    // sequencing
    // ************************************************************
    assign sw_start = wr && idx == IDX_CONTROL && pwdata[CTL_START];
    assign start_req = (soc_pulse || sw_start) && enable;
    assign more = burst_mode_enable && burst_left > 7'h01;
    assign launch = (state == st_idle && start_req && !track_mode_select)
        || (state == st_track && sar_tick && track_cnt == 2'(TRACK_SAR_CYCLES - 1))
        || (state == st_convert && core_done && more && !track_mode_select);
    assign to_track = (state == st_idle && start_req && track_mode_select)
        || (state == st_convert && core_done && more && track_mode_select);
    assign done_set = state == st_convert && core_done && !more;

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= st_idle;
        end else if (launch) begin
            state <= st_convert;
        end else if (to_track) begin
            state <= st_track;
        end else if (done_set) begin
            state <= st_idle;
        end
    end

    // conversion start pulse to the core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_start <= 1'b0;
        end else begin
            conv_start <= launch;
        end
    end

    // tracking time counted in sar clock ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            track_cnt <= 2'h0;
        end else if (state != st_track) begin
            track_cnt <= 2'h0;
        end else if (sar_tick) begin
            track_cnt <= track_cnt + 2'h1;
        end
    end

    // conversions left in the burst; repeat code ignored when burst is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_left <= 7'h01;
        end else if (state == st_idle && start_req) begin
            burst_left <= burst_mode_enable ? sac_repeat_total(repeat_count) : 7'h01;
        end else if (state == st_convert && core_done) begin
            burst_left <= burst_left - 7'h01;
        end
    end

    // ************************************************************
    // accumulator, hardware update wins over a software byte write
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= 16'h0000;
        end else if (state == st_convert && core_done) begin
            if (burst_mode_enable || accumulate_enable) begin
                acc <= acc + sample;
            end else begin
                acc <= sample;
            end
        end else if (state == st_idle && start_req && burst_mode_enable) begin
            acc <= 16'h0000;
        end else if (wr && idx == IDX_RES_LOW) begin
            acc[7:0] <= pwdata[7:0];
        end else if (wr && idx == IDX_RES_HIGH) begin
            acc[15:8] <= pwdata[7:0];
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_cfg <= RST_CONV_CFG;
        end else if (wr && idx == IDX_CONV_CFG) begin
            conv_cfg <= pwdata[REG_W-1:0];
        end
    end

    // accumulate enable is kept but never driven onto the read path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accumulate_enable <= RST_ACC_CFG[ACC_AE];
            shift_justify_select <= RST_ACC_CFG[ACC_SJ_LSB +: 3];
            repeat_count <= RST_ACC_CFG[ACC_RPT_LSB +: 3];
        end else if (wr && idx == IDX_ACC_CFG) begin
            accumulate_enable <= pwdata[ACC_AE];
            shift_justify_select <= pwdata[ACC_SJ_LSB +: 3];
            repeat_count <= pwdata[ACC_RPT_LSB +: 3];
        end
    end

    // control: enable and burst select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {burst_mode_enable, enable} <= RST_CONTROL;
        end else if (wr && idx == IDX_CONTROL) begin
            enable <= pwdata[CTL_ENABLE];
            burst_mode_enable <= pwdata[CTL_BURST];
        end
    end

    // done flag, write one to clear, a new completion beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_done_flag <= 1'b0;
        end else if (done_set) begin
            conversion_done_flag <= 1'b1;
        end else if (wr && idx == IDX_STATUS && pwdata[STS_DONE]) begin
            conversion_done_flag <= 1'b0;
        end
    end

    // interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_mask <= 1'b0;
        end else if (wr && idx == IDX_MASK) begin
            done_mask <= pwdata[STS_DONE];
        end
    end

    // ************************************************************
    // read path, sampled in the setup cycle for a zero-wait answer
    // ************************************************************
    always_comb begin
        mapped = 1'b1;
        rd_byte = 8'h00;
        unique case (idx)
            IDX_CONV_CFG: rd_byte = conv_cfg;
            IDX_ACC_CFG: rd_byte = {2'h0, shift_justify_select, repeat_count};
            IDX_RES_LOW: rd_byte = fmt[7:0];
            IDX_RES_HIGH: rd_byte = fmt[15:8];
            IDX_CONTROL: rd_byte = {5'h00, busy, burst_mode_enable, enable};
            IDX_STATUS: rd_byte = {7'h00, conversion_done_flag};
            IDX_MASK: rd_byte = {7'h00, done_mask};
            default: mapped = 1'b0;
        endcase
    end

    // read data and error answer stand through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr <= !mapped;
        end else if (!psel) begin
            pslverr <= 1'b0;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_normal_start: assert property (@(posedge pclk) disable iff (!presetn)
        state == st_idle && start_req && !track_mode_select |=> conv_start)
        else $error("normal track start did not launch at once");

    a_delayed_start: assert property (@(posedge pclk) disable iff (!presetn)
        state == st_idle && start_req && track_mode_select |=> !conv_start ##0 state == st_track)
        else $error("delayed track start launched without tracking");

    a_track_length: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(conv_start) && track_mode_select && $stable(track_mode_select)
        |-> $past(track_cnt, 1) == 2'(TRACK_SAR_CYCLES - 1))
        else $error("conversion began before three sar cycles of tracking");

    a_latest_only: assert property (@(posedge pclk) disable iff (!presetn)
        state == st_convert && core_done && !burst_mode_enable && !accumulate_enable
        |=> acc == $past(sample))
        else $error("latest result not held");

    a_eight_bit: assert property (@(posedge pclk) disable iff (!presetn)
        state == st_convert && core_done && !burst_mode_enable && !accumulate_enable && eight_bit_mode_select
        |=> acc[15:8] == 8'h00)
        else $error("eight bit result wider than eight bits");

    a_running_sum: assert property (@(posedge pclk) disable iff (!presetn)
        state == st_convert && core_done && (accumulate_enable || burst_mode_enable)
        |=> acc == $past(acc) + $past(sample))
        else $error("accumulator did not add the sample");

    a_ae_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && idx == IDX_ACC_CFG |=> prdata[ACC_AE] == 1'b0 && prdata[7] == 1'b0)
        else $error("accumulate enable visible on read");

    a_left_justify: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && idx == IDX_RES_LOW && shift_justify_select == SJ_LEFT
        |=> prdata[5:0] == 6'h00)
        else $error("left justified low bits not zero");

    a_burst_count: assert property (@(posedge pclk) disable iff (!presetn)
        done_set && burst_mode_enable |-> burst_left == 7'h01)
        else $error("burst ended before its count");

    a_done_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        done_set |=> conversion_done_flag ##1 (conversion_done_flag || $past(wr && idx == IDX_STATUS)))
        else $error("done flag not held until cleared");

    c_burst_done: cover property (@(posedge pclk) disable iff (!presetn) done_set && burst_mode_enable);
    c_track_conv: cover property (@(posedge pclk) disable iff (!presetn) conv_start && track_mode_select);
    c_accumulate: cover property (@(posedge pclk) disable iff (!presetn)
        core_done && accumulate_enable && !burst_mode_enable);
    c_irq_clear: cover property (@(posedge pclk) disable iff (!presetn) $fell(irq));

endmodule : sac_config_accum

`default_nettype wire

// File: sac_core_model.sv
// converter core stand-in: answers each start pulse with one result lat cycles later; lat 0 never answers
`default_nettype none

module sac_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic conv_start,
    input wire logic eight_bit_mode_select,
    input wire logic [3:0] lat,
    input wire logic [9:0] value,
    output logic core_done,
    output logic [9:0] core_result
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] cnt;

    // ************************************************************
    // one answer per start pulse, none when lat is 0
    // ************************************************************
    // result bus flips every cycle outside the done cycle, so stale data never passes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 4'h0;
            core_done <= 1'b0;
            core_result <= 10'h0;
        end else begin
            core_done <= 1'b0;
            core_result <= ~core_result;
            if (conv_start) begin
                cnt <= lat;
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end
            if (cnt == 4'h1) begin
                core_done <= 1'b1;
                // eight-bit mode: upper bits are junk that must be dropped
                core_result <= eight_bit_mode_select ? {~value[9:8], value[7:0]} : value;
            end
        end
    end
endmodule : sac_core_model

`default_nettype wire

// File: sac_pkg.sv
// constants, field layout and types for the converter configuration and accumulator block
//
// Notes on behaviour
// - sar clock is the system clock divided by one plus the five-bit divider field, bits 7:3; divider 0 holds sar_clk high.
// - normal track mode: conversion starts at once on start-of-conversion when enabled.
// - delayed track mode: three sar clock cycles of tracking, then conversion starts.
// - burst off: accumulate bit 0 keeps latest result, 1 keeps running sum.
// - accumulate enable is write-only and always reads back as zero.
// - shift-justify codes 0-3 right justify shifted by 0-3, code 4 left justifies.
// - in burst the repeat code 0-5 selects 1, 4, 8, 16, 32 or 64 conversions.
// - burst enable 0 selects single conversions, 1 selects burst operation.
// - done flag sets after a conversion or a whole burst, stays until cleared.
`default_nettype none

package sac_pkg;

    // ************************************************************
    // bus geometry
    // ************************************************************
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;

    // ************************************************************
    // register indices, byte address is four times the index
    // ************************************************************
    localparam logic [7:0] IDX_ACC_CFG = 8'hba;
    localparam logic [7:0] IDX_CONV_CFG = 8'hbc;
    localparam logic [7:0] IDX_RES_LOW = 8'hbd;
    localparam logic [7:0] IDX_RES_HIGH = 8'hbe;
    localparam logic [7:0] IDX_CONTROL = 8'hc0;
    localparam logic [7:0] IDX_STATUS = 8'hc1;
    localparam logic [7:0] IDX_MASK = 8'hc2;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CFG_DIV_LSB = 3;
    localparam int CFG_DIV_W = 5;
    localparam int CFG_EIGHT_BIT = 2;
    localparam int CFG_TRACK = 1;
    localparam int CFG_GAIN = 0;
    localparam int ACC_AE = 6;
    localparam int ACC_SJ_LSB = 3;
    localparam int ACC_RPT_LSB = 0;
    localparam int CTL_ENABLE = 0;
    localparam int CTL_BURST = 1;
    localparam int CTL_START = 2;
    localparam int STS_DONE = 0;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_CONV_CFG = 8'hf8;
    localparam logic [7:0] RST_ACC_CFG = 8'h00;
    localparam logic [1:0] RST_CONTROL = 2'h0;

    // ************************************************************
    // encodings and timing
    // ************************************************************
    localparam logic [2:0] SJ_LEFT = 3'h4;
    localparam int LEFT_SHIFT = 6;
    localparam int TRACK_SAR_CYCLES = 3;
    localparam int CLK_PERIOD_NS = 40;

    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_track = 3'b010,
        st_convert = 3'b100
    } sac_state_type;

    // repeat code to number of conversions, reserved codes give one
    function automatic logic [6:0] sac_repeat_total(input logic [2:0] code);
        unique case (code)
            3'h1: sac_repeat_total = 7'h04;
            3'h2: sac_repeat_total = 7'h08;
            3'h3: sac_repeat_total = 7'h10;
            3'h4: sac_repeat_total = 7'h20;
            3'h5: sac_repeat_total = 7'h40;
            default: sac_repeat_total = 7'h01;
        endcase
    endfunction : sac_repeat_total

endpackage : sac_pkg

`default_nettype wire

// File: sac_sar_divider.sv
// sar conversion clock divider from the system clock
`default_nettype none

module sac_sar_divider (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [sac_pkg::CFG_DIV_W-1:0] divider,
    output logic sar_clk,
    output logic sar_tick
);
    import sac_pkg::*;

    logic [CFG_DIV_W-1:0] cnt;
    logic [CFG_DIV_W-1:0] next_cnt;
    logic wrap;

    // period is divider plus one system clocks; a shrinking divider wraps early
    assign wrap = (cnt >= divider);
    assign next_cnt = wrap ? '0 : cnt + 1'b1;

    // ************************************************************
    // counter and outputs
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
            sar_tick <= 1'b0;
            sar_clk <= 1'b0;
        end else begin
            cnt <= next_cnt;
            sar_tick <= wrap;
            sar_clk <= (next_cnt <= (divider >> 1));
        end
    end

    a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        sar_tick && divider != '0 && $stable(divider) |=> !sar_tick)
        else $error("sar tick repeated with nonzero divider");

endmodule : sac_sar_divider

`default_nettype wire

// File: sar_adc_config_accumulator_tb_top.sv
// self-checking bench for the converter configuration and accumulator block
`default_nettype none

`define CHK(a, b) begin \
    num_checks++; \
    if ((a) !== (b)) begin \
        err_total++; \
        $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); \
    end \
end

module sar_adc_config_accumulator_tb_top;
    import sac_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [9:0] paddr = 10'h0;
    logic [31:0] pwdata = 32'h0;
    logic soc_pulse = 1'b0;
    logic [3:0] lat = 4'h1;
    logic [9:0] val = 10'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, core_done, conv_start, conv_track, sar_clk, eight_bit, gain, busy;
    logic [9:0] core_result;
    logic last_err, trk;
    logic [31:0] r;
    logic [15:0] r16, x;
    logic [9:0] v, v2;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    int n, p0, p3;

    always #20 pclk = ~pclk;

    sac_config_accum uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .soc_pulse(soc_pulse), .core_done(core_done), .core_result(core_result),
        .conv_start(conv_start), .conv_track(conv_track), .sar_clk(sar_clk),
        .eight_bit_mode_select(eight_bit), .amplifier_gain_select(gain), .busy(busy));

    sac_core_model core (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
        .eight_bit_mode_select(eight_bit), .lat(lat), .value(val), .core_done(core_done),
        .core_result(core_result));

    // ************************************************************
    // bus and conversion tasks
    // ************************************************************
    // request held until pready is sampled high, released only after that edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (pready !== 1'b1) err_total++;
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        apb(1'b1, idx, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] idx, output logic [31:0] q);
        apb(1'b0, idx, 8'h00, q);
    endtask : rd

    task automatic res(output logic [15:0] q);
        logic [31:0] lo, hi;
        rd(IDX_RES_LOW, lo);
        rd(IDX_RES_HIGH, hi);
        q = {hi[7:0], lo[7:0]};
    endtask : res

    // pulse start, count edges until the core is told to convert, then wait for idle
    task automatic conv(input logic [9:0] cv, output int cnt);
        int t;
        @(posedge pclk);
        val <= cv;
        lat <= 4'($urandom_range(1, 6));
        soc_pulse <= 1'b1;
        @(posedge pclk);
        soc_pulse <= 1'b0;
        trk = 1'b0;
        cnt = 0;
        do begin
            @(posedge pclk);
            cnt++;
            trk |= (conv_track === 1'b1);
        end while (conv_start !== 1'b1 && cnt < 500);
        if (conv_start !== 1'b1) err_total++;
        t = 0;
        while (busy !== 1'b0 && t < 5000) begin
            @(posedge pclk);
            t++;
        end
        if (busy !== 1'b0) err_total++;
    endtask : conv

    // sar clock period; the first rises may still run on the old divider
    task automatic per(input logic [4:0] d, output int p);
        int k, t;
        logic pv;
        wr(IDX_CONV_CFG, {d, 3'b000});
        k = 0;
        t = 0;
        p = 0;
        pv = sar_clk;
        while (k < 4 && t < 600) begin
            @(posedge pclk);
            t++;
            p++;
            if (pv === 1'b0 && sar_clk === 1'b1) begin
                k++;
                if (k < 4) p = 0;
            end
            pv = sar_clk;
        end
        if (k < 4) err_total++;
    endtask : per

    function automatic logic [15:0] fmt(input logic [15:0] a, input logic [2:0] c);
        if (c < 3'h4) return a >> c;
        if (c == 3'h4) return a << 6;
        return a;
    endfunction : fmt

    task automatic close_out();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    // hang guard well above the expected run length
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        void'($urandom(57));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(IDX_CONV_CFG, r);
        `CHK(r, 32'hf8);
        rd(IDX_ACC_CFG, r);
        `CHK(r, 32'h0);
        rd(8'h10, r);
        `CHK(last_err, 1'b1);
        // divider zero cannot make a registered clock toggle, so measure 1 and 3
        per(5'd1, p0);
        per(5'd3, p3);
        `CHK(p0, 2);
        `CHK(p3, 4);
        wr(IDX_MASK, 8'h01);
        wr(IDX_CONTROL, 8'h01);
        wr(IDX_CONV_CFG, 8'h05);
        // the write lands at the access edge, look one edge later
        @(posedge pclk);
        `CHK(eight_bit, 1'b1);
        `CHK(gain, 1'b1);
        v = 10'($urandom_range(0, 1023));
        conv(v, n);
        `CHK(n, 1);
        res(r16);
        `CHK(r16, {8'h0, v[7:0]});
        `CHK(irq, 1'b1);
        rd(IDX_STATUS, r);
        `CHK(r, 32'h1);
        wr(IDX_STATUS, 8'h01);
        rd(IDX_STATUS, r);
        `CHK(irq, 1'b0);
        // running sum, then cleared by software
        wr(IDX_CONV_CFG, 8'h00);
        wr(IDX_ACC_CFG, 8'h40);
        rd(IDX_ACC_CFG, r);
        `CHK(r, 32'h0);
        wr(IDX_RES_LOW, 8'h00);
        wr(IDX_RES_HIGH, 8'h00);
        v = 10'($urandom_range(0, 1023));
        v2 = 10'($urandom_range(0, 1023));
        conv(v, n);
        conv(v2, n);
        res(r16);
        `CHK(r16, 16'(v) + 16'(v2));
        wr(IDX_RES_LOW, 8'h00);
        wr(IDX_RES_HIGH, 8'h00);
        res(r16);
        `CHK(r16, 16'h0);
        wr(IDX_ACC_CFG, 8'h00);
        conv(v, n);
        conv(v2, n);
        res(r16);
        `CHK(r16, 16'(v2));
        // delayed tracking, divider 1: three sar cycles of six edges
        wr(IDX_CONV_CFG, 8'h0a);
        conv(v, n);
        `CHK(n >= 5 && n <= 9, 1'b1);
        `CHK(trk, 1'b1);
        for (int c = 0; c < 5; c++) begin
            x = 16'($urandom);
            wr(IDX_ACC_CFG, {2'b00, 3'(c), 3'b000});
            wr(IDX_RES_LOW, x[7:0]);
            wr(IDX_RES_HIGH, x[15:8]);
            res(r16);
            `CHK(r16, fmt(x, 3'(c)));
        end
        // repeat codes 0-5 in burst mode, done set after each burst
        wr(IDX_CONV_CFG, 8'h00);
        wr(IDX_CONTROL, 8'h03);
        for (int c = 0; c < 6; c++) begin
            wr(IDX_ACC_CFG, {5'h0, 3'(c)});
            v = 10'($urandom_range(0, 1023));
            conv(v, n);
            res(r16);
            `CHK(r16, 16'(((c == 0) ? 1 : (2 << c)) * v));
            rd(IDX_STATUS, r);
            `CHK(r, 32'h1);
            wr(IDX_STATUS, 8'h01);
        end
        wr(IDX_ACC_CFG, 8'h00);
        wr(IDX_CONTROL, 8'h01);
        // software start through the control register, single conversion
        wr(IDX_CONTROL, 8'h05);
        repeat (20) @(posedge pclk);
        res(r16);
        `CHK(r16, 16'(v));
        rd(IDX_STATUS, r);
        `CHK(r, 32'h1);
        close_out();
    end
endmodule : sar_adc_config_accumulator_tb_top

`undef CHK
`default_nettype wire
